// >>> include/prt_pkg.sv
// Shared constants and state types for the pulse and random timer block
package prt_pkg;
  localparam int PRT_CLK_PERIOD_NS = 10;
  // Repeat count limits for the edge-launched relay
  localparam logic [3:0] PRT_REPEAT_MIN = 4'h1;
  localparam logic [3:0] PRT_REPEAT_MAX = 4'h9;
  // Pseudo-random source
  localparam int PRT_LFSR_W = 16;
  localparam logic [15:0] PRT_LFSR_SEED = 16'hACE1;
  localparam logic [15:0] PRT_LFSR_TAPS = 16'hB400;
  // Values after reset
  localparam logic PRT_OUT_RST = 1'b0;
  localparam logic [3:0] PRT_CYCLES_RST = 4'h0;

  typedef enum logic [1:0] {
    PRT_W_IDLE,
    PRT_W_LOW,
    PRT_W_HIGH
  } prt_wipe_e;

  typedef enum logic [1:0] {
    PRT_P_OFF,
    PRT_P_HIGH,
    PRT_P_LOW
  } prt_pulse_e;

  typedef enum logic [1:0] {
    PRT_R_IDLE,
    PRT_R_ON_WAIT,
    PRT_R_OFF_WAIT
  } prt_rand_e;
endpackage

// >>> design/prt_timers.sv
// Edge-launched relay, pulse generator and random delay generator
// Operation
// - Launch rising edge starts low interval; output stays low.
// - After low interval, output high for high interval plus one clock, then low.
// - Relaunch before low plus high ends clears elapsed count and restarts.
// - Low/high cycle repeats configured count, limited to one through nine.
// - Relay clear zeroes elapsed count and drops output at once.
// - Each function has a retentivity option preserving its state, except the random generator elapsed count.
// - Enabled pulse generator alternates high interval then low interval.
// - Pulse generator runs while enable is high, stops when low.
// - Polarity flip inverts pulse output only while enabled.
// - Enable rise starts random on-delay from zero to high interval.
// - Output set when on-delay ends if enable stayed high.
// - Enable drop abandons on-delay; output unchanged.
// - Enable fall starts random off-delay from zero to low interval.
// - Output cleared when off-delay ends if enable stayed low.
// - Enable return high abandons off-delay; output stays set.
// - Power loss clears random generator elapsed count.
// - Intervals take constant or live value; timebase is configurable.
`timescale 1ns/1ns
module prt_timers
  import prt_pkg::*;
#(
  parameter int IW = 16,
  parameter int DW = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [DW-1:0] timebase_div_in,
  input wire logic power_loss_in,
  input wire logic [IW-1:0] live_value_in,
  input wire logic wipe_launch_in,
  input wire logic wipe_clear_in,
  input wire logic [3:0] wipe_repeat_in,
  input wire logic [IW-1:0] wipe_low_interval_in,
  input wire logic [IW-1:0] wipe_high_interval_in,
  input wire logic wipe_low_live_sel_in,
  input wire logic wipe_high_live_sel_in,
  input wire logic wipe_retain_in,
  input wire logic pulse_enable_in,
  input wire logic pulse_invert_in,
  input wire logic [IW-1:0] pulse_low_interval_in,
  input wire logic [IW-1:0] pulse_high_interval_in,
  input wire logic pulse_low_live_sel_in,
  input wire logic pulse_high_live_sel_in,
  input wire logic pulse_retain_in,
  input wire logic rand_enable_in,
  input wire logic [IW-1:0] rand_low_interval_in,
  input wire logic [IW-1:0] rand_high_interval_in,
  input wire logic rand_low_live_sel_in,
  input wire logic rand_high_live_sel_in,
  input wire logic rand_retain_in,
  output logic wipe_out,
  output logic [IW-1:0] wipe_elapsed_out,
  output logic pulse_out,
  output logic [IW-1:0] pulse_elapsed_out,
  output logic rand_out,
  output logic [IW-1:0] rand_elapsed_out
);
  function automatic logic [IW-1:0] pick(input logic sel, input logic [IW-1:0] fixed,
                                         input logic [IW-1:0] live);
    pick = sel ? live : fixed;
  endfunction
  function automatic logic [3:0] clamp_repeat(input logic [3:0] n);
    if (n < PRT_REPEAT_MIN) begin
      clamp_repeat = PRT_REPEAT_MIN;
    end else if (n > PRT_REPEAT_MAX) begin
      clamp_repeat = PRT_REPEAT_MAX;
    end else begin
      clamp_repeat = n;
    end
  endfunction
  // Maps a random word onto 0..lim inclusive, without a divider
  function automatic logic [IW-1:0] scale(input logic [PRT_LFSR_W-1:0] r,
                                          input logic [IW-1:0] lim);
    logic [IW+PRT_LFSR_W:0] p;
    p = (IW + PRT_LFSR_W + 1)'(r) * ((IW + PRT_LFSR_W + 1)'(lim) + 1'b1);
    scale = p[PRT_LFSR_W +: IW];
  endfunction
  // Timebase and sampling
  logic [DW-1:0] div_reg, div_next;
  logic tick_reg, tick_next;
  logic [PRT_LFSR_W-1:0] lfsr_reg, lfsr_next;
  logic launch_d_reg, pen_d_reg, ren_d_reg;
  logic launch_rise, pen_rise, ren_rise, ren_fall;

  always_comb begin
    tick_next = 1'b0;
    div_next = div_reg + 1'b1;
    if (div_reg + 1'b1 >= timebase_div_in) begin
      div_next = '0;
      tick_next = 1'b1;
    end
    lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ PRT_LFSR_TAPS) : (lfsr_reg >> 1);
  end
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
      lfsr_reg <= PRT_LFSR_SEED;
      launch_d_reg <= 1'b0;
      pen_d_reg <= 1'b0;
      ren_d_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
      lfsr_reg <= lfsr_next;
      launch_d_reg <= wipe_launch_in;
      pen_d_reg <= pulse_enable_in;
      ren_d_reg <= rand_enable_in;
    end
  end

  assign launch_rise = wipe_launch_in & ~launch_d_reg;
  assign pen_rise = pulse_enable_in & ~pen_d_reg;
  assign ren_rise = rand_enable_in & ~ren_d_reg;
  assign ren_fall = ~rand_enable_in & ren_d_reg;
  // Edge-launched relay
  prt_wipe_e w_state_reg, w_state_next;
  logic [IW-1:0] w_cnt_reg, w_cnt_next, w_low, w_high;
  logic [3:0] w_cyc_reg, w_cyc_next;
  logic w_out_reg, w_out_next;

  always_comb begin
    w_low = pick(wipe_low_live_sel_in, wipe_low_interval_in, live_value_in);
    w_high = pick(wipe_high_live_sel_in, wipe_high_interval_in, live_value_in);
    w_state_next = w_state_reg;
    w_cnt_next = w_cnt_reg;
    w_cyc_next = w_cyc_reg;
    case (w_state_reg)
      PRT_W_LOW: begin
        if (w_cnt_reg >= w_low) begin
          w_state_next = PRT_W_HIGH;
          w_cnt_next = '0;
        end else if (tick_reg) begin
          w_cnt_next = w_cnt_reg + 1'b1;
        end
      end
      PRT_W_HIGH: begin
        if (w_cnt_reg >= w_high) begin
          w_cnt_next = '0;
          if (w_cyc_reg + 1'b1 >= clamp_repeat(wipe_repeat_in)) begin
            w_state_next = PRT_W_IDLE;
            w_cyc_next = PRT_CYCLES_RST;
          end else begin
            w_state_next = PRT_W_LOW;
            w_cyc_next = w_cyc_reg + 1'b1;
          end
        end else if (tick_reg) begin
          w_cnt_next = w_cnt_reg + 1'b1;
        end
      end
      default: begin
        w_state_next = PRT_W_IDLE;
      end
    endcase
    // A relaunch mid-sequence restarts from the first low interval
    if (launch_rise) begin
      w_state_next = PRT_W_LOW;
      w_cnt_next = '0;
      w_cyc_next = PRT_CYCLES_RST;
    end
    if (power_loss_in && !wipe_retain_in) begin
      w_state_next = PRT_W_IDLE;
      w_cnt_next = '0;
      w_cyc_next = PRT_CYCLES_RST;
    end
    // Clear outranks a launch in the same cycle
    if (wipe_clear_in) begin
      w_state_next = PRT_W_IDLE;
      w_cnt_next = '0;
      w_cyc_next = PRT_CYCLES_RST;
    end
    w_out_next = (w_state_next == PRT_W_HIGH);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      w_state_reg <= PRT_W_IDLE;
      w_cnt_reg <= '0;
      w_cyc_reg <= PRT_CYCLES_RST;
      w_out_reg <= PRT_OUT_RST;
    end else begin
      w_state_reg <= w_state_next;
      w_cnt_reg <= w_cnt_next;
      w_cyc_reg <= w_cyc_next;
      w_out_reg <= w_out_next;
    end
  end

  // Pulse generator
  prt_pulse_e p_state_reg, p_state_next;
  logic [IW-1:0] p_cnt_reg, p_cnt_next, p_low, p_high;
  logic p_out_reg, p_out_next;

  always_comb begin
    p_low = pick(pulse_low_live_sel_in, pulse_low_interval_in, live_value_in);
    p_high = pick(pulse_high_live_sel_in, pulse_high_interval_in, live_value_in);
    p_state_next = p_state_reg;
    p_cnt_next = p_cnt_reg;
    case (p_state_reg)
      PRT_P_OFF: begin
        p_cnt_next = '0;
      end
      PRT_P_HIGH: begin
        if (p_cnt_reg >= p_high) begin
          p_state_next = PRT_P_LOW;
          p_cnt_next = '0;
        end else if (tick_reg) begin
          p_cnt_next = p_cnt_reg + 1'b1;
        end
      end
      PRT_P_LOW: begin
        if (p_cnt_reg >= p_low) begin
          p_state_next = PRT_P_HIGH;
          p_cnt_next = '0;
        end else if (tick_reg) begin
          p_cnt_next = p_cnt_reg + 1'b1;
        end
      end
      default: begin
        p_state_next = PRT_P_OFF;
      end
    endcase
    if (pen_rise || (pulse_enable_in && p_state_reg == PRT_P_OFF)) begin
      p_state_next = PRT_P_HIGH;
      p_cnt_next = '0;
    end
    if (power_loss_in && !pulse_retain_in) begin
      p_state_next = PRT_P_OFF;
      p_cnt_next = '0;
    end
    if (!pulse_enable_in) begin
      p_state_next = PRT_P_OFF;
      p_cnt_next = '0;
    end
    // Inversion only applies to a running generator
    if (p_state_next == PRT_P_OFF) begin
      p_out_next = 1'b0;
    end else begin
      p_out_next = (p_state_next == PRT_P_HIGH) ^ pulse_invert_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      p_state_reg <= PRT_P_OFF;
      p_cnt_reg <= '0;
      p_out_reg <= PRT_OUT_RST;
    end else begin
      p_state_reg <= p_state_next;
      p_cnt_reg <= p_cnt_next;
      p_out_reg <= p_out_next;
    end
  end

  // Random delay generator
  prt_rand_e r_state_reg, r_state_next;
  logic [IW-1:0] r_cnt_reg, r_cnt_next, r_tgt_reg, r_tgt_next, r_low, r_high;
  logic r_out_reg, r_out_next;

  always_comb begin
    r_low = pick(rand_low_live_sel_in, rand_low_interval_in, live_value_in);
    r_high = pick(rand_high_live_sel_in, rand_high_interval_in, live_value_in);
    r_state_next = r_state_reg;
    r_cnt_next = r_cnt_reg;
    r_tgt_next = r_tgt_reg;
    r_out_next = r_out_reg;
    case (r_state_reg)
      PRT_R_IDLE: begin
        r_cnt_next = '0;
      end
      PRT_R_ON_WAIT: begin
        if (r_cnt_reg >= r_tgt_reg) begin
          r_state_next = PRT_R_IDLE;
          r_out_next = 1'b1;
          r_cnt_next = '0;
        end else if (tick_reg) begin
          r_cnt_next = r_cnt_reg + 1'b1;
        end
      end
      PRT_R_OFF_WAIT: begin
        if (r_cnt_reg >= r_tgt_reg) begin
          r_state_next = PRT_R_IDLE;
          r_out_next = 1'b0;
          r_cnt_next = '0;
        end else if (tick_reg) begin
          r_cnt_next = r_cnt_reg + 1'b1;
        end
      end
      default: begin
        r_state_next = PRT_R_IDLE;
      end
    endcase
    // An opposite edge abandons the pending delay; output is left as it is
    if (ren_rise) begin
      r_state_next = PRT_R_ON_WAIT;
      r_cnt_next = '0;
      r_tgt_next = scale(lfsr_reg, r_high);
      r_out_next = r_out_reg;
    end else if (ren_fall) begin
      r_state_next = PRT_R_OFF_WAIT;
      r_cnt_next = '0;
      r_tgt_next = scale(lfsr_reg, r_low);
      r_out_next = r_out_reg;
    end
    if (power_loss_in) begin
      r_cnt_next = '0;
      if (!rand_retain_in) begin
        r_state_next = PRT_R_IDLE;
        r_out_next = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_state_reg <= PRT_R_IDLE;
      r_cnt_reg <= '0;
      r_tgt_reg <= '0;
      r_out_reg <= PRT_OUT_RST;
    end else begin
      r_state_reg <= r_state_next;
      r_cnt_reg <= r_cnt_next;
      r_tgt_reg <= r_tgt_next;
      r_out_reg <= r_out_next;
    end
  end

  assign wipe_out = w_out_reg;
  assign wipe_elapsed_out = w_cnt_reg;
  assign pulse_out = p_out_reg;
  assign pulse_elapsed_out = p_cnt_reg;
  assign rand_out = r_out_reg;
  assign rand_elapsed_out = r_cnt_reg;
endmodule

// >>> tb/prt_timers_assertions.sv
// Concurrent checks on the timer block ports
`timescale 1ns/1ns
module prt_timers_checker
  import prt_pkg::*;
#(
  parameter int IW = 16,
  parameter int DW = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [DW-1:0] timebase_div_in,
  input wire logic power_loss_in,
  input wire logic [IW-1:0] live_value_in,
  input wire logic wipe_launch_in,
  input wire logic wipe_clear_in,
  input wire logic [IW-1:0] wipe_high_interval_in,
  input wire logic wipe_high_live_sel_in,
  input wire logic pulse_enable_in,
  input wire logic pulse_invert_in,
  input wire logic rand_enable_in,
  input wire logic wipe_out,
  input wire logic [IW-1:0] wipe_elapsed_out,
  input wire logic pulse_out,
  input wire logic [IW-1:0] pulse_elapsed_out,
  input wire logic rand_out,
  input wire logic [IW-1:0] rand_elapsed_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic [31:0] run_reg, run_next, lim_t, hi_t, div_t;
  // Loose bound: two ticks of margin plus the transition clock
  always_comb begin
    hi_t = 32'(wipe_high_live_sel_in ? live_value_in : wipe_high_interval_in);
    div_t = (timebase_div_in == '0) ? 32'h0000_0001 : 32'(timebase_div_in);
    lim_t = (hi_t + 32'h0000_0002) * div_t + 32'h0000_0001;
    run_next = wipe_out ? run_reg + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_reg <= 32'h0000_0000;
    end else begin
      run_reg <= run_next;
    end
  end
  sequence wipe_start;
    $rose(wipe_launch_in) && !wipe_clear_in;
  endsequence
  sequence pulse_start;
    $rose(pulse_enable_in) && !pulse_invert_in && !power_loss_in;
  endsequence
  wipe_quiet_a: assert property (wipe_start |=> !wipe_out)
    else $error("relay output high right after launch");
  wipe_width_a: assert property (run_reg <= lim_t)
    else $error("relay pulse longer than high interval");
  clear_drop_a: assert property (wipe_clear_in |=> !wipe_out && wipe_elapsed_out == '0)
    else $error("relay clear did not drop output");
  pulse_start_a: assert property (pulse_start |=> pulse_out)
    else $error("pulse generator did not start high");
  pulse_off_a: assert property (!pulse_enable_in |=> !pulse_out && pulse_elapsed_out == '0)
    else $error("disabled pulse generator not idle");
  rand_rise_a: assert property ($rose(rand_out) |-> $past(rand_enable_in) && $past(rand_enable_in, 2))
    else $error("random output set without enable held");
  rand_fall_a: assert property ($fell(rand_out) && !$past(power_loss_in)
    |-> !$past(rand_enable_in) && !$past(rand_enable_in, 2))
    else $error("random output cleared without enable low");
  loss_zero_a: assert property (power_loss_in |=> rand_elapsed_out == '0)
    else $error("power loss left random elapsed count");
endmodule

// >>> tb/prt_load_model.sv
// Switched load model: counts output pulses and records level widths
`timescale 1ns/1ns
module prt_load_model (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clr_in,
  input wire logic sig_in,
  output logic [15:0] rises_out,
  output logic [15:0] high_w_out,
  output logic [15:0] low_w_out
);
  logic prev_reg;
  logic [15:0] run_reg;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {prev_reg, run_reg, rises_out, high_w_out, low_w_out} <= '0;
    end else if (clr_in) begin
      {run_reg, rises_out, high_w_out, low_w_out} <= '0;
      prev_reg <= sig_in;
    end else begin
      prev_reg <= sig_in;
      run_reg <= (sig_in != prev_reg) ? 16'h0001 : run_reg + 16'h0001;
      if (sig_in && !prev_reg) begin
        rises_out <= rises_out + 16'h0001;
        low_w_out <= run_reg;
      end
      if (!sig_in && prev_reg) begin
        high_w_out <= run_reg;
      end
    end
  end
endmodule

// >>> tb/prt_timers_bench.sv
// Self-checking bench for the pulse and random timer block
`timescale 1ns/1ns
module prt_timers_bench;
  import prt_pkg::*;
  logic sys_clk_in, rst_in, power_loss_in, wipe_launch_in, wipe_clear_in;
  logic wipe_low_live_sel_in, wipe_high_live_sel_in, wipe_retain_in;
  logic pulse_enable_in, pulse_invert_in, pulse_low_live_sel_in, pulse_high_live_sel_in;
  logic pulse_retain_in, rand_enable_in, rand_low_live_sel_in, rand_high_live_sel_in;
  logic rand_retain_in, wipe_out, pulse_out, rand_out, ld_clr, ld_sel;
  logic [15:0] timebase_div_in, live_value_in, wipe_low_interval_in, wipe_high_interval_in;
  logic [15:0] pulse_low_interval_in, pulse_high_interval_in, rand_low_interval_in;
  logic [15:0] rand_high_interval_in, wipe_elapsed_out, pulse_elapsed_out, rand_elapsed_out;
  logic [15:0] rises, hw, lw;
  logic [3:0] wipe_repeat_in;
  logic [3:0] reps [4] = '{4'h3, 4'h0, 4'h9, 4'hC};
  logic [15:0] exp_rises [4] = '{16'h0003, 16'h0001, 16'h0009, 16'h0009};
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  prt_timers prt_timers_i (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .timebase_div_in(timebase_div_in),
    .power_loss_in(power_loss_in), .live_value_in(live_value_in),
    .wipe_launch_in(wipe_launch_in), .wipe_clear_in(wipe_clear_in),
    .wipe_repeat_in(wipe_repeat_in), .wipe_low_interval_in(wipe_low_interval_in),
    .wipe_high_interval_in(wipe_high_interval_in), .wipe_low_live_sel_in(wipe_low_live_sel_in),
    .wipe_high_live_sel_in(wipe_high_live_sel_in), .wipe_retain_in(wipe_retain_in),
    .pulse_enable_in(pulse_enable_in), .pulse_invert_in(pulse_invert_in),
    .pulse_low_interval_in(pulse_low_interval_in),
    .pulse_high_interval_in(pulse_high_interval_in),
    .pulse_low_live_sel_in(pulse_low_live_sel_in),
    .pulse_high_live_sel_in(pulse_high_live_sel_in), .pulse_retain_in(pulse_retain_in),
    .rand_enable_in(rand_enable_in), .rand_low_interval_in(rand_low_interval_in),
    .rand_high_interval_in(rand_high_interval_in), .rand_low_live_sel_in(rand_low_live_sel_in),
    .rand_high_live_sel_in(rand_high_live_sel_in), .rand_retain_in(rand_retain_in),
    .wipe_out(wipe_out), .wipe_elapsed_out(wipe_elapsed_out), .pulse_out(pulse_out),
    .pulse_elapsed_out(pulse_elapsed_out), .rand_out(rand_out),
    .rand_elapsed_out(rand_elapsed_out));
  prt_load_model prt_load_model_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clr_in(ld_clr),
    .sig_in(ld_sel ? pulse_out : wipe_out), .rises_out(rises), .high_w_out(hw),
    .low_w_out(lw));
  initial begin
    sys_clk_in = 1'b0;
    forever #(PRT_CLK_PERIOD_NS / 2) sys_clk_in = ~sys_clk_in;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic fire(input int wait_n);
    ld_clr = 1'b1;
    step(1);
    ld_clr = 1'b0;
    wipe_launch_in = 1'b1;
    step(1);
    wipe_launch_in = 1'b0;
    step(wait_n);
  endtask
  task automatic wait_rand(input logic v, input int n);
    for (int i = 0; i < n && rand_out !== v; i++) step(1);
  endtask
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    {power_loss_in, wipe_launch_in, wipe_clear_in, wipe_low_live_sel_in, wipe_high_live_sel_in,
      wipe_retain_in, pulse_enable_in, pulse_invert_in, pulse_low_live_sel_in,
      pulse_high_live_sel_in, pulse_retain_in, rand_enable_in, rand_low_live_sel_in,
      rand_high_live_sel_in, ld_clr, ld_sel, live_value_in} = '0;
    {timebase_div_in, wipe_low_interval_in, wipe_high_interval_in} = {16'h0001, 16'h0002, 16'h0003};
    {pulse_low_interval_in, pulse_high_interval_in} = {16'h0001, 16'h0002};
    {rand_low_interval_in, rand_high_interval_in, rand_retain_in} = {16'h0004, 16'h0006, 1'b1};
    wipe_repeat_in = 4'h1;
    rst_in = 1'b1;
    step(2);
    rst_in = 1'b0;
    check("pulse idle", 16'(pulse_out), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wipe_repeat_in = reps[i];
      fire(80);
      check("relay pulses", rises, exp_rises[i]);
      check("relay width", hw, 16'h0004);
    end
    wipe_repeat_in = 4'h2;
    fire(4);
    check("relay high", 16'(wipe_out), 16'h0001);
    wipe_launch_in = 1'b1;
    step(1);
    wipe_launch_in = 1'b0;
    step(80);
    check("relaunch pulses", rises, 16'h0003);
    fire(4);
    wipe_clear_in = 1'b1;
    step(1);
    wipe_clear_in = 1'b0;
    check("clear out", 16'(wipe_out), 16'h0000);
    check("clear count", wipe_elapsed_out, 16'h0000);
    fire(4);
    power_loss_in = 1'b1;
    step(1);
    power_loss_in = 1'b0;
    check("loss relay", 16'(wipe_out), 16'h0000);
    {wipe_repeat_in, timebase_div_in} = {4'h1, 16'h0004};
    fire(60);
    check("tick width", 16'(hw >= 16'h0008 && hw <= 16'h000D), 16'h0001);
    {timebase_div_in, live_value_in, wipe_high_live_sel_in} = {16'h0001, 16'h0005, 1'b1};
    fire(40);
    check("live width", hw, 16'h0006);
    {ld_sel, pulse_enable_in} = 2'b11;
    step(20);
    check("pulse high", hw, 16'h0003);
    check("pulse low", lw, 16'h0002);
    pulse_invert_in = 1'b1;
    step(20);
    check("inverted high", hw, 16'h0002);
    check("inverted low", lw, 16'h0003);
    pulse_enable_in = 1'b0;
    step(2);
    check("pulse off", 16'(pulse_out), 16'h0000);
    rand_enable_in = 1'b1;
    wait_rand(1'b1, 10);
    check("random on", 16'(rand_out), 16'h0001);
    power_loss_in = 1'b1;
    step(1);
    power_loss_in = 1'b0;
    check("retained", 16'(rand_out), 16'h0001);
    check("loss count", rand_elapsed_out, 16'h0000);
    rand_enable_in = 1'b0;
    wait_rand(1'b0, 8);
    check("random off", 16'(rand_out), 16'h0000);
    rand_enable_in = 1'b1;
    wait_rand(1'b1, 10);
    // One low sample only: a longer gap could let a zero-length off-delay expire legally
    {rand_low_interval_in, rand_enable_in} = {16'h0FA0, 1'b0};
    step(1);
    rand_enable_in = 1'b1;
    step(1);
    check("off abandoned", 16'(rand_out), 16'h0001);
    step(5);
    check("still set", 16'(rand_out), 16'h0001);
    {rand_low_interval_in, rand_enable_in} = {16'h0004, 1'b0};
    wait_rand(1'b0, 8);
    {rand_high_interval_in, rand_enable_in} = {16'h0FA0, 1'b1};
    step(1);
    rand_enable_in = 1'b0;
    step(8);
    check("on abandoned", 16'(rand_out), 16'h0000);
    wipe_retain_in = 1'b1;
    fire(4);
    power_loss_in = 1'b1;
    step(1);
    power_loss_in = 1'b0;
    check("retained relay", 16'(wipe_out), 16'h0001);
    conclude();
  end
endmodule
bind prt_timers prt_timers_checker #(.IW(IW), .DW(DW)) prt_timers_checker_i (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .timebase_div_in(timebase_div_in),
  .power_loss_in(power_loss_in), .live_value_in(live_value_in),
  .wipe_launch_in(wipe_launch_in), .wipe_clear_in(wipe_clear_in),
  .wipe_high_interval_in(wipe_high_interval_in), .wipe_high_live_sel_in(wipe_high_live_sel_in),
  .pulse_enable_in(pulse_enable_in), .pulse_invert_in(pulse_invert_in),
  .rand_enable_in(rand_enable_in), .wipe_out(wipe_out), .wipe_elapsed_out(wipe_elapsed_out),
  .pulse_out(pulse_out), .pulse_elapsed_out(pulse_elapsed_out), .rand_out(rand_out),
  .rand_elapsed_out(rand_elapsed_out));
